// [core/break_deadtime_ctrl.sv]
// Contract
// - Compare write direct, or at update when preloaded
// - Active compare against counter drives channel 4
// - Input mode captures counter on capture event
// - Active break clears main output enable
// - Outputs idle unless main enable and channel enable
// - Auto enable sets main enable at update
// - Polarity bit picks break active level
// - Break enable gates break input
// - Run off-state bit drives inactive outputs
// - Idle off-state bit drives idle outputs
// - Lock one freezes idle, break, auto, deadtime
// - Lock two adds polarity and off-state bits
// - Lock three adds compare mode and preload
// - Lock field written once after reset
// - Code 0xx gives field times one clock
// - Code 10x gives 64 plus bits, two clocks
// - Codes 110/111 give 32 plus bits, 8/16
// - Deadtime field locked at any lock level
// - Complementary output settles at idle level
// - Main output takes idle level when disabled
// - Idle levels per channel, bit 7 zero
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "brk_dt_consts.svh"
module break_deadtime_ctrl
    import brk_dt_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Avalon-MM slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Timer core
    input wire logic [15:0] timer_counter_value,
    input wire logic update_event,
    input wire logic [1:0] ch4_direction_select,
    input wire logic ch4_preload_enable,
    input wire logic ch4_capture_event,
    input wire logic [2:0] oc_ref,
    input wire logic [3:0] channel_output_enable,
    input wire logic [2:0] comp_output_enable,
    input wire logic [3:0] channel_polarity,
    input wire logic [2:0] comp_polarity,
    // Break pin
    input wire logic break_input_pin,
    // Write protection seen by the rest of the timer
    output logic polarity_write_lock,
    output logic mode_write_lock,
    // Output pins
    output logic [3:0] ch_output,
    output logic [3:0] ch_output_en,
    output logic [2:0] complementary_output,
    output logic [2:0] complementary_output_en
);

    logic wait_ff;
    logic [31:0] rdata_ff;
    logic [15:0] ch4_compare_value_ff;
    logic [15:0] ch4_active_ff;
    logic ch4_ref_ff;
    logic main_output_enable_ff;
    logic auto_output_enable_ff;
    logic break_polarity_ff;
    logic break_enable_ff;
    logic run_off_state_select_ff;
    logic idle_off_state_select_ff;
    lock_level_type lock_ff;
    logic lock_written_ff;
    logic [7:0] deadtime_ff;
    logic [6:0] idle_levels_ff;
    logic pol_lock_ff;
    logic mode_lock_ff;
    logic [5:0] idx;
    logic wr_acc;
    logic ch4_is_out;
    logic brk_active;
    logic lock1;
    logic lock2;
    logic [7:0] wbyte;
    logic [7:0] nxt_rbyte;
    dt_cycles_type dt_cycles;
    logic [3:0] ref_all;
    logic [3:0] comp_en_all;
    logic [3:0] comp_pol_all;
    logic [7:0] idle_pad;
    logic [3:0] comp_lvl_all;
    logic [3:0] comp_oe_all;

    assign idx = avs_address[7:2];
    assign wbyte = avs_writedata[7:0];
    assign wr_acc = avs_write && !wait_ff && avs_byteenable[0];
    assign ch4_is_out = (ch4_direction_select == `DIR_OUTPUT);
    assign lock1 = (lock_ff != LOCK_OFF);
    assign lock2 = (lock_ff == LOCK_LVL2) || (lock_ff == LOCK_LVL3);

    assign brk_active = break_enable_ff &&
                        (break_input_pin == break_polarity_ff);

    // One wait cycle per access; a read is latched while waiting
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            wait_ff <= 1'b1;
        end else begin
            wait_ff <= !((avs_read || avs_write) && wait_ff);
        end
    end

    always_comb begin
        unique case (idx)
            `IDX_CH4_CMP_HIGH: nxt_rbyte = ch4_is_out ?
                ch4_compare_value_ff[15:8] : ch4_active_ff[15:8];
            `IDX_CH4_CMP_LOW: nxt_rbyte = ch4_is_out ?
                ch4_compare_value_ff[7:0] : ch4_active_ff[7:0];
            `IDX_BREAK_CTRL: nxt_rbyte = {main_output_enable_ff,
                auto_output_enable_ff, break_polarity_ff, break_enable_ff,
                run_off_state_select_ff, idle_off_state_select_ff, lock_ff};
            `IDX_DEADTIME: nxt_rbyte = deadtime_ff;
            `IDX_IDLE_LEVELS: nxt_rbyte = {1'b0, idle_levels_ff};
            default: nxt_rbyte = `RST_BYTE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            rdata_ff <= '0;
        end else if (avs_read && wait_ff) begin
            rdata_ff <= {24'h000000, nxt_rbyte};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            ch4_compare_value_ff <= {`RST_BYTE, `RST_BYTE};
            ch4_active_ff <= {`RST_BYTE, `RST_BYTE};
        end else if (!ch4_is_out) begin
            if (ch4_capture_event) begin
                ch4_compare_value_ff <= timer_counter_value;
                ch4_active_ff <= timer_counter_value;
            end
        end else begin
            if (wr_acc && idx == `IDX_CH4_CMP_HIGH) begin
                ch4_compare_value_ff[15:8] <= wbyte;
            end
            if (wr_acc && idx == `IDX_CH4_CMP_LOW) begin
                ch4_compare_value_ff[7:0] <= wbyte;
            end
            if (!ch4_preload_enable) begin
                if (wr_acc && idx == `IDX_CH4_CMP_HIGH) begin
                    ch4_active_ff[15:8] <= wbyte;
                end
                if (wr_acc && idx == `IDX_CH4_CMP_LOW) begin
                    ch4_active_ff[7:0] <= wbyte;
                end
            end else if (update_event) begin
                ch4_active_ff <= ch4_compare_value_ff;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            ch4_ref_ff <= 1'b0;
        end else begin
            ch4_ref_ff <= ch4_is_out &&
                          (timer_counter_value < ch4_active_ff);
        end
    end

    // main output enable; break wins over any set
    // Clears on the first edge the pin is active, not through a gate,
    // so a pin pulse shorter than one clock cycle may be missed
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            main_output_enable_ff <= 1'b0;
        end else if (brk_active) begin
            main_output_enable_ff <= 1'b0;
        end else if (wr_acc && idx == `IDX_BREAK_CTRL) begin
            main_output_enable_ff <= wbyte[`BK_MOE] ||
                (auto_output_enable_ff && update_event);
        end else if (auto_output_enable_ff && update_event) begin
            main_output_enable_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            auto_output_enable_ff <= 1'b0;
            break_polarity_ff <= 1'b0;
            break_enable_ff <= 1'b0;
            run_off_state_select_ff <= 1'b0;
            idle_off_state_select_ff <= 1'b0;
            lock_ff <= LOCK_OFF;
            lock_written_ff <= 1'b0;
        end else if (wr_acc && idx == `IDX_BREAK_CTRL) begin
            lock_written_ff <= 1'b1;
            if (!lock_written_ff) begin
                lock_ff <= lock_level_type'(
                    wbyte[`BK_LOCK_HI:`BK_LOCK_LO]);
            end
            if (!lock1) begin
                auto_output_enable_ff <= wbyte[`BK_AOE];
                break_polarity_ff <= wbyte[`BK_POL];
                break_enable_ff <= wbyte[`BK_ENA];
            end
            if (!lock2) begin
                run_off_state_select_ff <= wbyte[`BK_RUN_OFF_STATE_SELECT];
                idle_off_state_select_ff <= wbyte[`BK_IDLE_OFF_STATE_SELECT];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            deadtime_ff <= `RST_BYTE;
            idle_levels_ff <= 7'h00;
        end else if (wr_acc && !lock1) begin
            if (idx == `IDX_DEADTIME) begin
                deadtime_ff <= wbyte;
            end
            if (idx == `IDX_IDLE_LEVELS) begin
                idle_levels_ff <= 7'(wbyte & `OIS_USED_MASK);
            end
        end
    end

    // protection flags for the channel registers
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            pol_lock_ff <= 1'b0;
            mode_lock_ff <= 1'b0;
        end else begin
            pol_lock_ff <= lock2;
            mode_lock_ff <= (lock_ff == LOCK_LVL3);
        end
    end

    always_comb begin
        casez (deadtime_ff[7:5])
            3'b0??: dt_cycles = {2'b00, deadtime_ff};
            3'b10?: dt_cycles = dt_cycles_type'((`DT_BASE_64 +
                {4'h0, deadtime_ff[5:0]}) << `DT_SHIFT_2);
            3'b110: dt_cycles = dt_cycles_type'((`DT_BASE_32 +
                {5'h00, deadtime_ff[4:0]}) << `DT_SHIFT_8);
            default: dt_cycles = dt_cycles_type'((`DT_BASE_32 +
                {5'h00, deadtime_ff[4:0]}) << `DT_SHIFT_16);
        endcase
    end

    assign ref_all = {ch4_ref_ff, oc_ref};
    assign comp_en_all = {1'b0, comp_output_enable};
    assign comp_pol_all = {1'b0, comp_polarity};
    assign idle_pad = {1'b0, idle_levels_ff};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_ch
            dt_output_stage #(
                .HAS_COMP(gi < 3)
            ) u_stage (
                .clk_sys(clk_sys),
                .nrst(nrst),
                .ref_level(ref_all[gi]),
                .dt_cycles(dt_cycles),
                .main_output_enable(main_output_enable_ff),
                .run_off_state_select(run_off_state_select_ff),
                .idle_off_state_select(idle_off_state_select_ff),
                .ch_en(channel_output_enable[gi]),
                .comp_en(comp_en_all[gi]),
                .ch_pol(channel_polarity[gi]),
                .comp_pol(comp_pol_all[gi]),
                .idle_lvl(idle_pad[2*gi]),
                .comp_idle_lvl(idle_pad[2*gi+1]),
                .out_lvl_ff(ch_output[gi]),
                .out_en_ff(ch_output_en[gi]),
                .comp_lvl_ff(comp_lvl_all[gi]),
                .comp_en_ff(comp_oe_all[gi])
            );
        end
    endgenerate

    // Channel 4 has no complementary pin; its stage ties those to 0
    assign complementary_output = comp_lvl_all[2:0];
    assign complementary_output_en = comp_oe_all[2:0];

    assign avs_readdata = rdata_ff;
    assign avs_waitrequest = wait_ff;
    assign polarity_write_lock = pol_lock_ff;
    assign mode_write_lock = mode_lock_ff;

    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    property p_ch4_direct;
        wr_acc && idx == `IDX_CH4_CMP_LOW && ch4_is_out &&
        !ch4_preload_enable |=> ch4_active_ff[7:0] == $past(wbyte);
    endproperty
    a_ch4_direct: assert property (p_ch4_direct)
        else $error("direct compare write not applied");

    property p_ch4_preload;
        ch4_is_out && ch4_preload_enable && update_event &&
        !wr_acc |=> ch4_active_ff == $past(ch4_compare_value_ff);
    endproperty
    a_ch4_preload: assert property (p_ch4_preload)
        else $error("preload not moved at update");

    property p_ch4_ref;
        ch4_is_out ##1 ch4_is_out |->
        ch4_ref_ff == ($past(timer_counter_value) < $past(ch4_active_ff));
    endproperty
    a_ch4_ref: assert property (p_ch4_ref)
        else $error("compare reference wrong");

    property p_capture;
        !ch4_is_out && ch4_capture_event |=>
        ch4_active_ff == $past(timer_counter_value);
    endproperty
    a_capture: assert property (p_capture)
        else $error("capture value not latched");

    property p_break_clear;
        brk_active |=> !main_output_enable_ff;
    endproperty
    a_break_clear: assert property (p_break_clear)
        else $error("break did not clear main enable");

    property p_auto_set;
        auto_output_enable_ff && update_event && !brk_active
        |=> main_output_enable_ff;
    endproperty
    a_auto_set: assert property (p_auto_set)
        else $error("auto enable failed at update");

    property p_break_gated;
        main_output_enable_ff && !break_enable_ff &&
        !(wr_acc && idx == `IDX_BREAK_CTRL) |=> main_output_enable_ff;
    endproperty
    a_break_gated: assert property (p_break_gated)
        else $error("disabled break changed main enable");

    property p_dt_locked;
        lock1 && wr_acc && idx == `IDX_DEADTIME |=> $stable(deadtime_ff);
    endproperty
    a_dt_locked: assert property (p_dt_locked)
        else $error("deadtime written under lock");

    property p_lock_once;
        lock_written_ff |=> $stable(lock_ff);
    endproperty
    a_lock_once: assert property (p_lock_once)
        else $error("lock field changed twice");

    property p_ois_bit7;
        avs_read && !wait_ff && idx == `IDX_IDLE_LEVELS
        |-> avs_readdata[7] == 1'b0;
    endproperty
    a_ois_bit7: assert property (p_ois_bit7)
        else $error("idle register bit 7 not zero");

    property p_idle_off;
        !main_output_enable_ff && !idle_off_state_select_ff [*2]
        |=> ch_output_en == 4'h0;
    endproperty
    a_idle_off: assert property (p_idle_off)
        else $error("output enabled while idle and off");

    c_break: cover property (main_output_enable_ff ##1 brk_active);
    c_auto: cover property (!main_output_enable_ff ##1
                            main_output_enable_ff);
    c_capture: cover property (!ch4_is_out && ch4_capture_event);
    c_locked: cover property (lock1 && wr_acc && idx == `IDX_DEADTIME);

endmodule : break_deadtime_ctrl

// [core/brk_dt_consts.svh]
`ifndef BRK_DT_CONSTS_SVH
`define BRK_DT_CONSTS_SVH

// Register indices; byte address is four times the index
`define IDX_CH4_CMP_HIGH 6'h1B
`define IDX_CH4_CMP_LOW 6'h1C
`define IDX_BREAK_CTRL 6'h1D
`define IDX_DEADTIME 6'h1E
`define IDX_IDLE_LEVELS 6'h1F

// Reset value of every register
`define RST_BYTE 8'h00

// break_control fields
`define BK_MOE 7
`define BK_AOE 6
`define BK_POL 5
`define BK_ENA 4
`define BK_RUN_OFF_STATE_SELECT 3
`define BK_IDLE_OFF_STATE_SELECT 2
`define BK_LOCK_HI 1
`define BK_LOCK_LO 0

// output_idle_levels: bit 7 reads as zero
`define OIS_USED_MASK 8'h7F

// Deadtime code bases and step shifts
`define DT_BASE_64 10'h040
`define DT_BASE_32 10'h020
`define DT_SHIFT_2 1
`define DT_SHIFT_8 3
`define DT_SHIFT_16 4

// Channel-4 direction code for output
`define DIR_OUTPUT 2'h0

`endif

// [core/brk_dt_pkg.sv]
package brk_dt_pkg;

    typedef enum logic [1:0] {
        LOCK_OFF = 2'h0,
        LOCK_LVL1 = 2'h1,
        LOCK_LVL2 = 2'h2,
        LOCK_LVL3 = 2'h3
    } lock_level_type;

    typedef logic [9:0] dt_cycles_type;

endpackage : brk_dt_pkg

// [core/dt_output_stage.sv]
`timescale 1ns/1ps
module dt_output_stage
    import brk_dt_pkg::*;
#(
    parameter bit HAS_COMP = 1'b1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Reference and setup
    input wire logic ref_level,
    input wire dt_cycles_type dt_cycles,
    input wire logic main_output_enable,
    input wire logic run_off_state_select,
    input wire logic idle_off_state_select,
    input wire logic ch_en,
    input wire logic comp_en,
    input wire logic ch_pol,
    input wire logic comp_pol,
    input wire logic idle_lvl,
    input wire logic comp_idle_lvl,
    // Pins
    output logic out_lvl_ff,
    output logic out_en_ff,
    output logic comp_lvl_ff,
    output logic comp_en_ff
);

    logic ref_q_ff;
    logic moe_q_ff;
    dt_cycles_type dt_cnt_ff;
    logic settled;
    logic main_act;
    logic comp_act;
    logic nxt_out_lvl;
    logic nxt_out_en;
    logic nxt_comp_lvl;
    logic nxt_comp_en;

    assign settled = (dt_cnt_ff == '0);
    assign main_act = (HAS_COMP && comp_en) ? (ref_q_ff & settled)
                                            : ref_level;
    assign comp_act = ~ref_q_ff & settled;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            ref_q_ff <= 1'b0;
            moe_q_ff <= 1'b0;
            dt_cnt_ff <= '0;
        end else begin
            ref_q_ff <= ref_level;
            moe_q_ff <= main_output_enable;
            if ((ref_level != ref_q_ff) || (moe_q_ff && !main_output_enable)) begin
                dt_cnt_ff <= dt_cycles;
            end else if (!settled) begin
                dt_cnt_ff <= dt_cnt_ff - 1'b1;
            end
        end
    end

    always_comb begin
        if (main_output_enable) begin
            nxt_out_en = ch_en | (run_off_state_select & HAS_COMP & comp_en);
            nxt_out_lvl = ch_en ? (main_act ^ ch_pol) : ch_pol;
            nxt_comp_en = HAS_COMP & (comp_en | (run_off_state_select & ch_en));
            nxt_comp_lvl = comp_en ? (comp_act ^ comp_pol) : comp_pol;
        end else begin
            nxt_out_en = idle_off_state_select & (ch_en | (HAS_COMP & comp_en));
            nxt_out_lvl = (settled || !HAS_COMP) ? idle_lvl : ch_pol;
            nxt_comp_en = HAS_COMP & idle_off_state_select & (ch_en | comp_en);
            nxt_comp_lvl = settled ? comp_idle_lvl : comp_pol;
        end
        if (!HAS_COMP) begin
            nxt_comp_en = 1'b0;
            nxt_comp_lvl = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            out_lvl_ff <= 1'b0;
            out_en_ff <= 1'b0;
            comp_lvl_ff <= 1'b0;
            comp_en_ff <= 1'b0;
        end else begin
            out_lvl_ff <= nxt_out_lvl;
            out_en_ff <= nxt_out_en;
            comp_lvl_ff <= nxt_comp_lvl;
            comp_en_ff <= nxt_comp_en;
        end
    end

endmodule : dt_output_stage

// [tb/power_stage_model.sv]
`timescale 1ns/1ps
module power_stage_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Gate drives from the timer
    input wire logic [2:0] hi_lvl,
    input wire logic [2:0] hi_en,
    input wire logic [2:0] lo_lvl,
    input wire logic [2:0] lo_en,
    // Sticky fault seen by the bench
    output logic shoot_through_ff
);
    logic [2:0] both_on;
    // Both switches of one leg on at once shorts the supply
    assign both_on = hi_lvl & hi_en & lo_lvl & lo_en;
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            shoot_through_ff <= 1'b0;
        end else if (|both_on) begin
            shoot_through_ff <= 1'b1;
        end
    end
endmodule : power_stage_model

// [tb/break_deadtime_ctrl_test.sv]
`timescale 1ns/1ps
`include "brk_dt_consts.svh"
module break_deadtime_ctrl_test;
    localparam logic [7:0] A_HI = {`IDX_CH4_CMP_HIGH, 2'b00};
    localparam logic [7:0] A_LO = {`IDX_CH4_CMP_LOW, 2'b00};
    localparam logic [7:0] A_BK = {`IDX_BREAK_CTRL, 2'b00};
    localparam logic [7:0] A_DT = {`IDX_DEADTIME, 2'b00};
    localparam logic [7:0] A_OI = {`IDX_IDLE_LEVELS, 2'b00};
    logic clk_sys, nrst, rd_en, wr_en, waitreq, upd, pre, cap, pin;
    logic [7:0] addr, q;
    logic [31:0] wdata, rdata;
    logic [15:0] cnt;
    logic [1:0] dir;
    logic [2:0] oref, cen, cout, coen;
    logic [3:0] chen, chout, choen;
    logic plock, mlock, shoot;
    int fails, checks_done, lvl, base, got;
    logic [7:0] code [4] = '{8'h05, 8'h83, 8'hC1, 8'hE0};
    int dt [4] = '{5, 134, 264, 512};

    break_deadtime_ctrl dut (.clk_sys(clk_sys), .nrst(nrst),
        .avs_address(addr), .avs_read(rd_en), .avs_write(wr_en),
        .avs_writedata(wdata), .avs_byteenable(4'hF),
        .avs_readdata(rdata), .avs_waitrequest(waitreq),
        .timer_counter_value(cnt), .update_event(upd),
        .ch4_direction_select(dir), .ch4_preload_enable(pre),
        .ch4_capture_event(cap), .oc_ref(oref),
        .channel_output_enable(chen), .comp_output_enable(cen),
        .channel_polarity(4'h0), .comp_polarity(3'h0),
        .break_input_pin(pin), .polarity_write_lock(plock),
        .mode_write_lock(mlock), .ch_output(chout),
        .ch_output_en(choen), .complementary_output(cout),
        .complementary_output_en(coen));

    power_stage_model stage (.clk_sys(clk_sys), .nrst(nrst),
        .hi_lvl(chout[2:0]), .hi_en(choen[2:0]), .lo_lvl(cout),
        .lo_en(coen), .shoot_through_ff(shoot));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task complete_run;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run

    task check(input string what, input logic [31:0] exp,
               input logic [31:0] seen);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Holds the request until waitrequest is sampled low
    task bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int k;
        addr <= a;
        wdata <= {24'h000000, d};
        wr_en <= wr;
        rd_en <= ~wr;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (waitreq !== 1'b0 && k < 50);
        q = rdata[7:0];
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        if (waitreq !== 1'b0) begin
            fails++;
            complete_run();
        end
        @(posedge clk_sys);
    endtask : bus

    task rd(input logic [7:0] a, input logic [7:0] exp, input string w);
        bus(1'b0, a, 8'h00);
        check(w, exp, q);
    endtask : rd

    task pulse_upd;
        upd <= 1'b1;
        @(posedge clk_sys);
        upd <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask : pulse_upd

    task do_reset;
        nrst <= 1'b0;
        repeat (8) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (2) @(posedge clk_sys);
    endtask : do_reset

    // Gap between complementary turn-off and main turn-on
    task dt_gap(output int c);
        int k;
        oref <= 3'h0;
        repeat (600) @(posedge clk_sys);
        oref <= 3'h1;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (cout[0] !== 1'b0 && k < 20);
        c = 0;
        while (chout[0] !== 1'b1 && c < 1000) begin
            @(posedge clk_sys);
            c++;
        end
        if (c >= 1000 || k >= 20) begin
            fails++;
            complete_run();
        end
    endtask : dt_gap

    initial begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        complete_run();
    end

    initial begin
        {nrst, rd_en, wr_en, upd, pre, cap, pin, dir} = '0;
        {addr, wdata, cnt, oref} = '0;
        chen = 4'hF;
        cen = 3'h7;
        fails = 0;
        checks_done = 0;
        do_reset();
        foreach (code[i])
            rd(A_HI + 8'(4 * i), 8'h00, "reset value");
        rd(A_OI, 8'h00, "idle reset");
        rd(8'h00, 8'h00, "unmapped");
        bus(1'b1, A_OI, 8'hFF);
        rd(A_OI, 8'h7F, "idle levels");
        bus(1'b1, A_OI, 8'h5A);
        $display("test registers done");
        // Main, auto, polarity, break enable and idle off-state bits set in the first write; run off-state and lock left 0
        bus(1'b1, A_BK, 8'hF4);
        bus(1'b1, A_HI, 8'h12);
        bus(1'b1, A_LO, 8'h34);
        cnt <= 16'h1233;
        repeat (3) @(posedge clk_sys);
        check("ch4 below", 1, chout[3]);
        cnt <= 16'h1234;
        repeat (3) @(posedge clk_sys);
        check("ch4 equal", 0, chout[3]);
        pre <= 1'b1;
        bus(1'b1, A_LO, 8'h40);
        cnt <= 16'h1238;
        repeat (3) @(posedge clk_sys);
        check("ch4 preload", 0, chout[3]);
        rd(A_LO, 8'h40, "preload");
        pulse_upd();
        check("ch4 update", 1, chout[3]);
        dir <= 2'h1;
        cnt <= 16'hBEEF;
        @(posedge clk_sys);
        cap <= 1'b1;
        @(posedge clk_sys);
        cap <= 1'b0;
        rd(A_HI, 8'hBE, "capture hi");
        rd(A_LO, 8'hEF, "capture lo");
        dir <= 2'h0;
        $display("test compare done");
        pin <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd(A_BK, 8'h74, "break clear");
        repeat (10) @(posedge clk_sys);
        check("idle main", 4'hC, chout);
        check("idle comp", 3'h3, cout);
        check("idle en", 7'h7F, {choen, coen});
        pulse_upd();
        rd(A_BK, 8'h74, "auto blocked");
        pin <= 1'b0;
        pulse_upd();
        rd(A_BK, 8'hF4, "auto set");
        bus(1'b1, A_BK, 8'hD4);
        rd(A_BK, 8'h54, "low break");
        bus(1'b1, A_BK, 8'h44);
        bus(1'b1, A_BK, 8'hC4);
        rd(A_BK, 8'hC4, "break off");
        bus(1'b1, A_BK, 8'h40);
        repeat (4) @(posedge clk_sys);
        check("idle off", 7'h00, {choen, coen});
        chen <= 4'h0;
        cen <= 3'h0;
        bus(1'b1, A_BK, 8'hC0);
        repeat (4) @(posedge clk_sys);
        check("run off", 7'h00, {choen, coen});
        cen <= 3'h7;
        bus(1'b1, A_BK, 8'hC8);
        repeat (4) @(posedge clk_sys);
        check("run on", 7'h3F, {choen, coen});
        chen <= 4'hF;
        cen <= 3'h7;
        $display("test break done");
        bus(1'b1, A_DT, 8'h00);
        dt_gap(base);
        foreach (code[i]) begin
            bus(1'b1, A_DT, code[i]);
            dt_gap(got);
            check("deadtime", dt[i], got - base);
        end
        check("overlap", 0, shoot);
        $display("test deadtime done");
        for (lvl = 0; lvl < 4; lvl++) begin
            do_reset();
            bus(1'b1, A_DT, 8'h11);
            bus(1'b1, A_BK, {4'h0, 2'b11, lvl[1:0]});
            bus(1'b1, A_DT, 8'h22);
            bus(1'b1, A_OI, 8'h33);
            bus(1'b1, A_BK, 8'h73);
            rd(A_BK, {1'b0, (lvl > 0) ? 3'b000 : 3'b111,
                (lvl > 1) ? 2'b11 : 2'b00, lvl[1:0]}, "lock");
            rd(A_DT, (lvl > 0) ? 8'h11 : 8'h22, "dt lock");
            rd(A_OI, (lvl > 0) ? 8'h00 : 8'h33, "idle lock");
            check("pol lock", lvl > 1, plock);
            check("mode lock", lvl == 3, mlock);
        end
        $display("test lock done");
        complete_run();
    end
endmodule : break_deadtime_ctrl_test
